//--- rtl/sbm_consts.svh
/*
  Constants of the serial boot front end: command codes, acknowledge codes,
  password area and timing limits. Included by every module file of the block.
*/
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH

// mode bytes and their acknowledges
`define SBM_MODE_UART       8'h86
`define SBM_MODE_IO         8'h30
// commands
`define SBM_CMD_RAM_XFER    8'h10
`define SBM_CMD_ERASE       8'h40
`define SBM_CMD_ERASE_EN    8'h54
// acknowledge low nibbles and fixed codes
`define SBM_ACK_RX_ERR      4'h8
`define SBM_ACK_BAD         4'h1
`define SBM_ACK_PW_ERR      8'h11
`define SBM_ACK_RX_ERR_XFER 8'h18
`define SBM_ERASED          8'h FF
// stored password area
`define SBM_PW_BASE         32'h3F87_FFF4
`define SBM_PW_LEN          4'hC
// reset value of the last command nibble
`define SBM_CMD_RESET       8'h00
// timing: timer width and programmable uart bit time window, given in ns and converted to clock cycles
`define SBM_TIMER_W         16
`define SBM_CLK_NS          10
`define SBM_BIT_MIN_NS      1000
`define SBM_BIT_MAX_NS      650000
`define SBM_BIT_MIN_CYC     ((`SBM_BIT_MIN_NS + `SBM_CLK_NS - 1) / `SBM_CLK_NS)
`define SBM_BIT_MAX_CYC     (`SBM_BIT_MAX_NS / `SBM_CLK_NS)

`endif

//--- rtl/sbm_pkg.sv
/*
  Types shared by the serial boot front end: state enums, usb step codes
  and the byte arithmetic helper. Assumes nothing of its surroundings.
*/
package sbm_pkg;

  typedef enum logic [2:0] {
    DET_IDLE, DET_WAIT_B, DET_WAIT_C, DET_WAIT_D, DET_DONE
  } sbm_det_t;

  typedef enum logic [3:0] {
    ST_DETECT, ST_SEND, ST_ABORT, ST_CMD, ST_PW_LOAD, ST_PW_RX,
    ST_SUM_EVAL, ST_XFER, ST_ERASE_EN
  } sbm_state_t;

  typedef enum logic [3:0] {
    USB_START, USB_SEND_PW, USB_CONF_PW, USB_SEND_INFO, USB_CONF_INFO,
    USB_RAW, USB_SEND_SUM, USB_CONF_SUM, USB_ERASE_START, USB_RUN_ERASE,
    USB_CONF_ERASE
  } sbm_usb_step_t;

  // modulo 256 sum, carries dropped
  function automatic logic [7:0] sbm_add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction

endpackage

//--- rtl/sbm_mode_detect.sv
/*
  Times the first four edges of the first serial byte and decides between
  uart and clocked mode. Assumes the receive pin idles high and that the
  caller arms it only while serial reception is still off.
*/
`timescale 1ns/100ps
`include "sbm_consts.svh"

module sbm_mode_detect #(
  parameter int CNT_W = `SBM_TIMER_W
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             serial_pin,
  output logic                  done,
  output logic                  is_uart,
  output logic [CNT_W-1:0]      interval_a_to_b
);
  import sbm_pkg::*;

  logic             pin_meta;
  logic             pin_sync;
  logic             pin_prev;
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] interval_a_to_c;
  logic [CNT_W-1:0] interval_a_to_d;
  logic [CNT_W-1:0] interval_c_to_d;
  sbm_det_t         det;

  assign interval_c_to_d = interval_a_to_d - interval_a_to_c;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end else if (ce) begin
      pin_meta <= serial_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // free running from edge a, saturating so a stalled line cannot wrap
  always_ff @(posedge clock) begin
    if (!nrst) begin
      timer <= '0;
    end else if (ce) begin
      if (det == DET_IDLE) begin
        timer <= '0;
      end else if (timer != '1) begin
        timer <= timer + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      det             <= DET_IDLE;
      interval_a_to_b <= '0;
      interval_a_to_c <= '0;
      interval_a_to_d <= '0;
    end else if (ce) begin
      case (det)
        DET_IDLE:   if (pin_prev && !pin_sync) det <= DET_WAIT_B;
        DET_WAIT_B: if (!pin_prev && pin_sync) begin
          interval_a_to_b <= timer;
          det             <= DET_WAIT_C;
        end
        DET_WAIT_C: if (pin_prev && !pin_sync) begin
          interval_a_to_c <= timer;
          det             <= DET_WAIT_D;
        end
        DET_WAIT_D: if (!pin_prev && pin_sync) begin
          interval_a_to_d <= timer;
          det             <= DET_DONE;
        end
        DET_DONE:   det <= DET_DONE;
        default:    det <= DET_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      done    <= 1'b0;
      is_uart <= 1'b0;
    end else if (ce && det == DET_DONE && !done) begin
      done    <= 1'b1;
      // uart when a-b not longer than c-d
      // clocked mode when a-b is longer
      is_uart <= (interval_a_to_b <= interval_c_to_d);
    end
  end

endmodule // sbm_mode_detect

//--- rtl/sbm_checksum.sv
/*
  Running modulo 256 sum of received bytes. The block checks a sequence that
  ends in its checksum byte, so a correct sequence sums to zero.
  Assumes add strobes come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "sbm_consts.svh"

module sbm_checksum (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       clear,
  input  wire logic       add,
  input  wire logic [7:0] data,
  output logic      [7:0] sum,
  output logic      [7:0] check_byte
);
  import sbm_pkg::*;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sum        <= 8'h00;
      check_byte <= 8'h00;
    end else if (ce) begin
      if (clear) begin
        sum        <= 8'h00;
        check_byte <= 8'h00;
      end else if (add) begin
        sum        <= sbm_add8(sum, data);
        check_byte <= sbm_add8(~sbm_add8(sum, data), 8'h01);
      end
    end
  end

endmodule // sbm_checksum

//--- rtl/sbm_boot_front.sv
/*
  Serial boot front end: mode detection from the first byte, command echo,
  stored password check and checksum acknowledge for the ram transfer
  command, plus an order tracker for usb boot and flash erase steps.
  Assumes a byte receiver and transmitter on the same clock, a flash read
  port with one cycle latency, and a ram transfer engine that reports done.
*/
// Notes on behaviour
// - with reception off, time each edge of the first byte; the code times only the first four edges.
// - uart chosen when interval a to b not longer than c to d.
// - clocked mode chosen when interval a to b longer than c to d.
// - first bytes 0x91, 0xa1, 0xb1 also pick clocked mode; reply 0x30.
// - after echoing 0x10, read twelve stored password bytes from flash.
// - stored bytes all equal and not 0xff answer checksum byte with 0x11.
// - received bytes five to sixteen must all match the stored password; the code compares the twelve bytes that follow the command.
// - password check runs whether or not security is enabled.
// - checksum is modulo 256 sum, then its two's complement.
// - usb boot steps follow a fixed order; device answers start and confirms.
// - flash erase steps follow a fixed order; device answers each step; the code leaves USB_SEND_PW unanswered.
// - acknowledge mode byte; stay silent if uart bit time is unusable.
// - ack upper nibble from command, bit 3 receive error, bit 0 error.
`timescale 1ns/100ps
`include "sbm_consts.svh"

module sbm_boot_front #(
  parameter int CNT_W   = `SBM_TIMER_W,
  parameter int BIT_MIN = `SBM_BIT_MIN_CYC,
  parameter int BIT_MAX = `SBM_BIT_MAX_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire logic                  boot_serial_channel_rx,
  output logic                       rx_enable,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_err,
  output logic                       tx_valid,
  output logic [7:0]                 tx_data,
  input  wire logic                  tx_ready,
  output logic                       mode_uart,
  output logic                       mode_io,
  output logic                       mode_abort,
  output logic [CNT_W-1:0]           bit_time,
  output logic                       flash_rd_en,
  output logic [31:0]                flash_rd_addr,
  input  wire logic [7:0]            flash_rd_data,
  output logic                       xfer_start,
  input  wire logic                  xfer_done,
  output logic                       erase_start,
  input  wire logic                  usb_step_valid,
  input  wire sbm_pkg::sbm_usb_step_t usb_step,
  output logic                       usb_resp_valid,
  output logic                       usb_resp_ok
);
  import sbm_pkg::*;

  sbm_state_t       state;
  sbm_state_t       ret_state;
  logic             det_done;
  logic             det_uart;
  logic [CNT_W-1:0] det_a_to_b;
  logic [7:0]       stored_pw [0:11];
  logic [3:0]       idx;
  logic             rd_pend;
  logic [3:0]       rd_idx;
  logic [7:0]       last_cmd;
  logic             pw_bad;
  logic             rx_err_seen;
  logic [7:0]       sum;
  logic             sum_clear;
  logic             sum_add;
  logic             area_err;
  logic             rx_err_use;
  logic             baud_ok;
  sbm_usb_step_t    usb_expect;
  logic             usb_fault;
  logic             usb_erase;

  sbm_mode_detect #(
    .CNT_W(CNT_W)
  ) u_detect (
    .clock           (clock),
    .nrst            (nrst),
    .ce              (ce && state == ST_DETECT),
    .serial_pin      (boot_serial_channel_rx),
    .done            (det_done),
    .is_uart         (det_uart),
    .interval_a_to_b (det_a_to_b)
  );

  sbm_checksum u_sum (
    .clock      (clock),
    .nrst       (nrst),
    .ce         (ce),
    .clear      (sum_clear),
    .add        (sum_add),
    .data       (rx_data),
    .sum        (sum),
    .check_byte ()
  );

  assign sum_clear  = (state == ST_PW_LOAD);
  assign sum_add    = (state == ST_PW_RX) && rx_valid;
  // receive errors are only meaningful with an asynchronous line
  assign rx_err_use = rx_err && mode_uart;
  assign baud_ok    = (det_a_to_b >= CNT_W'(BIT_MIN)) && (det_a_to_b <= CNT_W'(BIT_MAX));

  // all stored bytes equal and not erased
  always_comb begin
    area_err = (stored_pw[0] != `SBM_ERASED);
    for (int i = 1; i < 12; i++) begin
      if (stored_pw[i] != stored_pw[0]) area_err = 1'b0;
    end
  end

  // main sequencer; ack bytes are held in tx_data until the transmitter takes them
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state       <= ST_DETECT;
      ret_state   <= ST_CMD;
      tx_valid    <= 1'b0;
      tx_data     <= 8'h00;
      mode_uart   <= 1'b0;
      mode_io     <= 1'b0;
      mode_abort  <= 1'b0;
      bit_time    <= '0;
      rx_enable   <= 1'b0;
      last_cmd    <= `SBM_CMD_RESET;
      idx         <= 4'h0;
      pw_bad      <= 1'b0;
      rx_err_seen <= 1'b0;
      xfer_start  <= 1'b0;
      erase_start <= 1'b0;
    end else if (ce) begin
      xfer_start  <= 1'b0;
      erase_start <= 1'b0;
      case (state)
        ST_DETECT: if (det_done) begin
          bit_time <= det_a_to_b;
          if (det_uart && !baud_ok) begin
            // silent abort on unusable bit time
            mode_abort <= 1'b1;
            state      <= ST_ABORT;
          end else begin
            mode_uart <= det_uart;
            mode_io   <= !det_uart;
            tx_data   <= det_uart ? `SBM_MODE_UART : `SBM_MODE_IO;
            tx_valid  <= 1'b1;
            rx_enable <= 1'b1;
            ret_state <= ST_CMD;
            state     <= ST_SEND;
          end
        end
        ST_SEND: if (tx_ready) begin
          tx_valid <= 1'b0;
          state    <= ret_state;
          if (ret_state == ST_XFER) xfer_start <= 1'b1;
        end
        ST_ABORT: state <= ST_ABORT;
        ST_CMD: if (rx_valid) begin
          tx_valid  <= 1'b1;
          state     <= ST_SEND;
          ret_state <= ST_CMD;
          // errors keep the previous command nibble
          if (rx_err_use) begin
            tx_data <= {last_cmd[7:4], `SBM_ACK_RX_ERR};
          end else if (rx_data == `SBM_CMD_RAM_XFER) begin
            // echo, then fetch the stored password
            last_cmd  <= rx_data;
            tx_data   <= rx_data;
            ret_state <= ST_PW_LOAD;
            idx       <= 4'h0;
          end else if (rx_data == `SBM_CMD_ERASE) begin
            last_cmd  <= rx_data;
            tx_data   <= rx_data;
            ret_state <= ST_ERASE_EN;
          end else begin
            tx_data <= {last_cmd[7:4], `SBM_ACK_BAD};
          end
        end
        ST_ERASE_EN: if (rx_valid) begin
          tx_valid  <= 1'b1;
          state     <= ST_SEND;
          ret_state <= ST_CMD;
          if (rx_err_use) begin
            tx_data <= {last_cmd[7:4], `SBM_ACK_RX_ERR};
          end else if (rx_data == `SBM_CMD_ERASE_EN) begin
            tx_data     <= rx_data;
            erase_start <= 1'b1;
          end else begin
            tx_data <= {last_cmd[7:4], `SBM_ACK_BAD};
          end
        end
        // bytes arriving during the short load would be lost; a serial byte
        // lasts far longer than the twelve reads, so this is not expected
        ST_PW_LOAD: if (rd_pend && rd_idx == `SBM_PW_LEN - 4'h1) begin
          state       <= ST_PW_RX;
          idx         <= 4'h0;
          pw_bad      <= 1'b0;
          rx_err_seen <= 1'b0;
        end
        ST_PW_RX: if (rx_valid) begin
          rx_err_seen <= rx_err_seen || rx_err_use;
          if (idx == `SBM_PW_LEN) begin
            state <= ST_SUM_EVAL;
          end else begin
            // no bypass for a secured part
            if (rx_data != stored_pw[idx]) pw_bad <= 1'b1;
            idx <= idx + 4'h1;
          end
        end
        ST_SUM_EVAL: begin
          tx_valid  <= 1'b1;
          state     <= ST_SEND;
          ret_state <= ST_CMD;
          if (rx_err_seen) begin
            tx_data <= `SBM_ACK_RX_ERR_XFER;
          end else if (area_err || pw_bad || sum != 8'h00) begin
            // errors go back to the command wait
            tx_data <= `SBM_ACK_PW_ERR;
          end else begin
            tx_data   <= last_cmd;
            ret_state <= ST_XFER;
          end
        end
        ST_XFER: if (xfer_done) state <= ST_CMD;
        default: state <= ST_DETECT;
      endcase
    end
  end

  // flash reads of the password area, one cycle latency
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flash_rd_en   <= 1'b0;
      flash_rd_addr <= 32'h0000_0000;
      rd_pend       <= 1'b0;
      rd_idx        <= 4'h0;
    end else if (ce) begin
      rd_pend <= flash_rd_en;
      rd_idx  <= 4'(flash_rd_addr - `SBM_PW_BASE);
      if (state == ST_SEND && ret_state == ST_PW_LOAD && tx_ready) begin
        flash_rd_en   <= 1'b1;
        flash_rd_addr <= `SBM_PW_BASE;
      end else if (flash_rd_en && flash_rd_addr == `SBM_PW_BASE + 32'h0000_000B) begin
        flash_rd_en <= 1'b0;
      end else if (flash_rd_en) begin
        flash_rd_addr <= flash_rd_addr + 32'h0000_0001;
      end
    end
  end

  // the read index follows the address; idx is otherwise idle in this state
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 12; i++) stored_pw[i] <= `SBM_ERASED;
    end else if (ce && rd_pend) begin
      stored_pw[rd_idx] <= flash_rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      usb_expect     <= USB_START;
      usb_fault      <= 1'b0;
      usb_erase      <= 1'b0;
      usb_resp_valid <= 1'b0;
      usb_resp_ok    <= 1'b0;
    end else if (ce) begin
      usb_resp_valid <= 1'b0;
      if (usb_step_valid) begin
        case (usb_step)
          USB_START, USB_ERASE_START: begin
            usb_fault      <= 1'b0;
            usb_erase      <= (usb_step == USB_ERASE_START);
            usb_expect     <= USB_SEND_PW;
            usb_resp_valid <= 1'b1;
            usb_resp_ok    <= 1'b1;
          end
          USB_SEND_PW, USB_SEND_INFO, USB_SEND_SUM: begin
            if (usb_step != usb_expect) usb_fault <= 1'b1;
            usb_expect <= sbm_usb_step_t'(usb_step + 4'h1);
          end
          USB_RAW: begin
            if (usb_expect != USB_RAW) usb_fault <= 1'b1;
            usb_expect <= USB_RAW;
          end
          default: begin
            // confirms and run answer; ok only when in order and clean
            usb_resp_valid <= 1'b1;
            usb_resp_ok    <= !usb_fault && (usb_step == usb_expect ||
                              (usb_step == USB_SEND_SUM && usb_expect == USB_RAW));
            usb_expect     <= USB_START;
            if (usb_step == usb_expect && !usb_fault) begin
              case (usb_step)
                USB_CONF_PW:   usb_expect <= usb_erase ? USB_RUN_ERASE : USB_SEND_INFO;
                USB_CONF_INFO: usb_expect <= USB_RAW;
                USB_RUN_ERASE: usb_expect <= USB_CONF_ERASE;
                default:       usb_expect <= USB_START;
              endcase
            end
          end
        endcase
        // raw data ends when the sum is sent
        if (usb_step == USB_SEND_SUM && usb_expect == USB_RAW) begin
          usb_fault  <= usb_fault;
          usb_expect <= USB_CONF_SUM;
        end
      end
    end
  end

endmodule // sbm_boot_front

//--- tb/sbm_boot_front_chk.sv
/*
  Port assertions for the serial boot front end, bound to its top module.
  Assumes ce stays high and that everything runs on one clock.
*/
`timescale 1ns/100ps
module sbm_boot_front_chk
  import sbm_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   nrst,
  input wire logic                   rx_enable,
  input wire logic                   tx_valid,
  input wire logic [7:0]             tx_data,
  input wire logic                   tx_ready,
  input wire logic                   mode_uart,
  input wire logic                   mode_io,
  input wire logic                   mode_abort,
  input wire logic                   flash_rd_en,
  input wire logic [31:0]            flash_rd_addr,
  input wire logic                   xfer_start,
  input wire logic                   erase_start,
  input wire logic                   usb_step_valid,
  input wire sbm_pkg::sbm_usb_step_t usb_step,
  input wire logic                   usb_resp_valid,
  input wire logic                   usb_resp_ok
);
  logic took_ram;

  // a transfer may only follow a good acknowledge that was really taken
  assign took_ram = tx_valid && tx_ready && tx_data == 8'h10;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_quiet_pre_mode: assert property (
    !(mode_uart || mode_io) |-> !tx_valid && !rx_enable)
    else $error("output active before a mode was chosen");
  chk_one_mode: assert property (
    $onehot0({mode_uart, mode_io, mode_abort}))
    else $error("more than one mode flag set");
  chk_mode_kept: assert property (
    (mode_uart || mode_io || mode_abort) |=> $stable({mode_uart, mode_io, mode_abort}))
    else $error("mode changed after the choice");
  chk_mode_echo: assert property (
    $rose(mode_uart) || $rose(mode_io)
      |-> tx_valid && rx_enable && tx_data == (mode_uart ? 8'h86 : 8'h30))
    else $error("wrong acknowledge of the mode byte");
  chk_ack_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("acknowledge dropped before it was taken");
  chk_ack_bits: assert property (
    tx_valid && !(tx_data inside {8'h86, 8'h54}) |-> tx_data[2:1] == 2'b00)
    else $error("acknowledge bits 2 and 1 not zero");
  chk_pw_first: assert property (
    $rose(flash_rd_en) |-> flash_rd_addr == 32'h3F87_FFF4)
    else $error("password read does not start at the area base");
  chk_pw_walk: assert property (
    flash_rd_en && flash_rd_addr != 32'h3F87_FFFF
      |=> flash_rd_en && flash_rd_addr == $past(flash_rd_addr) + 32'h1)
    else $error("password reads not consecutive");
  chk_xfer_cause: assert property (
    xfer_start |-> $past(took_ram) || $past(took_ram, 2))
    else $error("transfer started without a good acknowledge");
  chk_erase_echo: assert property (
    erase_start |-> ##[0:1] (tx_valid && tx_data == 8'h54))
    else $error("erase started without its echo");
  chk_usb_start: assert property (
    usb_step_valid && usb_step inside {USB_START, USB_ERASE_START}
      |=> usb_resp_valid && usb_resp_ok)
    else $error("start step not answered ok");
  chk_usb_cause: assert property (
    usb_resp_valid |-> $past(usb_step_valid))
    else $error("usb answer without a step");
endmodule // sbm_boot_front_chk

bind sbm_boot_front sbm_boot_front_chk u_chk (
  .clock, .nrst, .rx_enable, .tx_valid, .tx_data, .tx_ready, .mode_uart, .mode_io,
  .mode_abort, .flash_rd_en, .flash_rd_addr, .xfer_start, .erase_start, .usb_step_valid,
  .usb_step, .usb_resp_valid, .usb_resp_ok
);

//--- tb/sbm_ctrl_model.sv
/*
  Programming controller stand-in: sends the mode byte on the serial pin,
  hands received bytes to the block and takes its acknowledges.
  Assumes it shares the block's clock; the pin idles high.
*/
`timescale 1ns/100ps
module sbm_ctrl_model (
  input  wire logic       clock,
  output logic            pin,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  initial begin
    pin = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_err = 1'b0;
    tx_ready = 1'b0;
  end

  // first byte, lsb first at the chosen bit time
  task automatic send_mode(input logic [9:0] pat, input int bitc);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock) pin <= pat[i];
      repeat (bitc - 1) @(posedge clock);
    end
    @(posedge clock) pin <= 1'b1;
  endtask

  // stale data is inverted so nothing can lean on a held value
  task automatic put_byte(input logic [7:0] b, input logic err);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_err <= err;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    rx_err <= ~err;
  endtask

  // give up when no acknowledge comes in time
  task automatic get_ack(output logic [7:0] d, input int slow);
    int i;
    for (i = 0; i < 3000 && tx_valid !== 1'b1; i++) @(negedge clock);
    repeat (slow) @(negedge clock);
    d = (tx_valid === 1'b1) ? tx_data : 'x;
    @(posedge clock) tx_ready <= 1'b1;
    @(posedge clock) tx_ready <= 1'b0;
  endtask
endmodule // sbm_ctrl_model

//--- tb/sbm_boot_front_tb.sv
/*
  Self-checking bench for the serial boot front end: mode byte timing,
  command acknowledges, password and checksum, erase echo and usb order.
  Assumes the controller model and a flash port with one cycle latency.
*/
`timescale 1ns/100ps
module sbm_boot_front_tb;
  import sbm_pkg::*;

  // narrowed uart bit window for a 160 ns link bit
  localparam int BIT_MIN = 8;
  localparam int BIT_MAX = 100;
  localparam int BITC    = 16;

  logic          clock = 1'b0;
  logic          nrst = 1'b0;
  logic          ce = 1'b1;
  logic          boot_serial_channel_rx, rx_enable, rx_valid, rx_err, tx_valid, tx_ready;
  logic          mode_uart, mode_io, mode_abort, flash_rd_en, xfer_start, erase_start;
  logic          xfer_done = 1'b0;
  logic          usb_step_valid = 1'b0;
  logic          usb_resp_valid, usb_resp_ok;
  logic [7:0]    rx_data, tx_data;
  logic [7:0]    flash_rd_data = 8'h00;
  logic [15:0]   bit_time;
  logic [31:0]   flash_rd_addr;
  sbm_usb_step_t usb_step = USB_START;
  logic [7:0]    pw_mem [12];
  int            fails = 0;
  int            checks = 0;
  int            cycles = 0;

  sbm_boot_front #(.BIT_MIN(BIT_MIN), .BIT_MAX(BIT_MAX)) DUT (
    .clock, .nrst, .ce, .boot_serial_channel_rx, .rx_enable, .rx_valid, .rx_data, .rx_err,
    .tx_valid, .tx_data, .tx_ready, .mode_uart, .mode_io, .mode_abort, .bit_time,
    .flash_rd_en, .flash_rd_addr, .flash_rd_data, .xfer_start, .xfer_done, .erase_start,
    .usb_step_valid, .usb_step, .usb_resp_valid, .usb_resp_ok
  );
  sbm_ctrl_model m (
    .clock, .pin(boot_serial_channel_rx), .rx_valid, .rx_data, .rx_err, .tx_valid,
    .tx_data, .tx_ready
  );

  always #5 clock = ~clock;

  always @(posedge clock)
    flash_rd_data <= flash_rd_en ? pw_mem[flash_rd_addr[3:0] - 4'h4] : ~flash_rd_data;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic ack_is(input logic [7:0] e, input int slow);
    logic [7:0] d;
    m.get_ack(d, slow);
    cmp8("ack", e, d);
  endtask

  task automatic send(input logic [7:0] b, input logic err, input logic [7:0] e);
    m.put_byte(b, err);
    ack_is(e, 0);
  endtask

  task automatic t_uart();
    do_reset();
    m.send_mode({1'b1, 8'h86, 1'b0}, BITC);
    ack_is(8'h86, 3);
    cmp1("mode_uart", 1'b1, mode_uart);
    cmp1("rx_enable", 1'b1, rx_enable);
    cmp1("bit_time", 1'b1, bit_time >= 16'(2*BITC-1) && bit_time <= 16'(2*BITC+1));
  endtask

  task automatic t_cmd();
    send(8'h00, 1'b1, 8'h08);
    send(8'h07, 1'b0, 8'h01);
  endtask

  task automatic t_ram(input int kind, input logic [7:0] fill, input logic [7:0] e);
    logic [7:0] sum;
    logic [7:0] b;
    sum = 8'h00;
    // unique password unless a fill is asked for
    for (int i = 0; i < 12; i++) pw_mem[i] = (fill === 8'h00) ? 8'hA0 + 8'(i) : fill;
    send(8'h10, 1'b0, 8'h10);
    repeat (14) @(posedge clock);
    for (int i = 0; i < 12; i++) begin
      b = pw_mem[i] ^ ((kind == 1 && i == 7) ? 8'h01 : 8'h00);
      sum = sum + b;
      m.put_byte(b, kind == 3 && i == 3);
    end
    m.put_byte(8'h00 - sum + ((kind == 2) ? 8'h01 : 8'h00), 1'b0);
    ack_is(e, 2);
    if (e === 8'h10) begin
      for (int j = 0; j < 4; j++) begin
        @(negedge clock);
        if (xfer_start === 1'b1) break;
      end
      cmp1("xfer_start", 1'b1, xfer_start);
      @(posedge clock) xfer_done <= 1'b1;
      @(posedge clock) xfer_done <= 1'b0;
    end
  endtask

  task automatic t_erase();
    send(8'h40, 1'b0, 8'h40);
    m.put_byte(8'h54, 1'b0);
    @(negedge clock);
    cmp1("erase_start", 1'b1, erase_start);
    ack_is(8'h54, 0);
    send(8'h40, 1'b0, 8'h40);
    send(8'h33, 1'b0, 8'h41);
    send(8'h07, 1'b0, 8'h41);
    send(8'h40, 1'b0, 8'h40);
    send(8'h54, 1'b1, 8'h48);
  endtask

  task automatic t_usb();
    sbm_usb_step_t seq [18] = '{USB_START, USB_SEND_PW, USB_CONF_PW, USB_SEND_INFO,
      USB_CONF_INFO, USB_RAW, USB_RAW, USB_SEND_SUM, USB_CONF_SUM, USB_START, USB_SEND_PW,
      USB_SEND_INFO, USB_CONF_PW, USB_ERASE_START, USB_SEND_PW, USB_CONF_PW,
      USB_RUN_ERASE, USB_CONF_ERASE};
    logic [17:0] rsp = 18'h3B315;
    logic [17:0] ok = 18'h3A315;
    foreach (seq[i]) begin
      @(posedge clock);
      usb_step_valid <= 1'b1;
      usb_step <= seq[i];
      @(posedge clock);
      usb_step_valid <= 1'b0;
      @(negedge clock);
      cmp1("usb_resp_valid", rsp[i], usb_resp_valid);
      if (rsp[i]) cmp1("usb_resp_ok", ok[i], usb_resp_ok);
    end
  endtask

  task automatic t_io();
    logic [7:0] codes [4] = '{8'h30, 8'h91, 8'hA1, 8'hB1};
    foreach (codes[i]) begin
      do_reset();
      m.send_mode({2'b11, codes[i]}, BITC);
      ack_is(8'h30, 0);
      cmp1("mode_io", 1'b1, mode_io);
      cmp1("mode_uart", 1'b0, mode_uart);
    end
  endtask

  // bit times on both sides of the usable uart window
  task automatic t_abort();
    int bt [2] = '{3, 60};
    foreach (bt[i]) begin
      do_reset();
      m.send_mode({1'b1, 8'h86, 1'b0}, bt[i]);
      for (int j = 0; j < 40 && mode_abort !== 1'b1; j++) @(negedge clock);
      cmp1("mode_abort", 1'b1, mode_abort);
      cmp1("tx_valid", 1'b0, tx_valid);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    t_uart();
    t_cmd();
    t_ram(0, 8'h00, 8'h10);
    t_ram(1, 8'h00, 8'h11);
    t_ram(2, 8'h00, 8'h11);
    t_ram(3, 8'h00, 8'h18);
    t_ram(0, 8'h5A, 8'h11);
    t_ram(0, 8'hFF, 8'h10);
    t_erase();
    t_usb();
    t_io();
    t_abort();
    give_verdict();
  end
endmodule // sbm_boot_front_tb
